// ### rtz_pkg.sv
// Constants shared by the return-to-zero pulser control logic
// Assumes a 25 MHz clk and a 32-bit APB register bus
package rtz_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;

  // Control register fields and reset value
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_BP_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;

  // Status register fields
  localparam int          STAT_EN_BIT   = 0;
  localparam int          STAT_RDY_BIT  = 1;
  localparam int          STAT_BP_BIT   = 2;
  localparam int          STAT_CODE_LSB = 4;
  localparam int          STAT_DRV_LSB  = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Drive codes, bit 3 = A down to bit 0 = D
  localparam logic [3:0]  DRIVE_DEFAULT = 4'hA;
  localparam logic [3:0]  DRIVE_CODE00  = 4'h9;
  localparam logic [3:0]  DRIVE_CODE01  = 4'hE;
  localparam logic [3:0]  DRIVE_CODE10  = 4'h2;
  localparam logic [3:0]  DRIVE_CODE11  = 4'hA;
  localparam logic [1:0]  RETIME_RESET  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          SYNC_EDGES    = 2;
  localparam int          ON_TIME_NS    = 5000;
  localparam int          OFF_TIME_NS   = 4000;
  localparam int          ON_CYCLES     = (ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OFF_CYCLES    = OFF_TIME_NS / CLK_PERIOD_NS;
  // Power-up count leaves room for the pin synchroniser edges, so a pulse at 5 us is kept
  localparam logic [6:0]  ON_COUNT      = 7'(ON_CYCLES - SYNC_EDGES);

endpackage : rtz_pkg

// ### rtz_decode_if.sv
// Carries the selected control code to the decoder and the drive pattern back
// Assumes both ends sit on the same clock
`timescale 1ns/1ps
interface rtz_decode_if;
  logic [1:0] code;
  logic [3:0] drive;

  // Decoder end and user end
  modport dec  (input code, output drive);
  modport user (output code, input drive);
endinterface : rtz_decode_if

// ### rtz_decoder.sv
// Combinational decode of the two control inputs into four gate drives
// Assumes the caller selects retimed or live code
`timescale 1ns/1ps
module rtz_decoder
  import rtz_pkg::*;
(
  // Code in, drive out
  rtz_decode_if.dec dif
);

  ////////////////////////////////////////////////////////////////////////////////
  // Truth table, first input is the high code bit
  always_comb begin
    unique case (dif.code)
      2'h0: dif.drive = DRIVE_CODE00;
      2'h1: dif.drive = DRIVE_CODE01;
      2'h2: dif.drive = DRIVE_CODE10;
      2'h3: dif.drive = DRIVE_CODE11;
    endcase
  end

endmodule : rtz_decoder

// ### rtz_pulser_retime.sv
// Control logic of a four-output three-level return-to-zero pulser driver
// Assumes enable and bypass pins are asynchronous; control inputs share clk
`timescale 1ns/1ps
module rtz_pulser_retime
  import rtz_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Pins from the beamformer
  input  wire logic        pulser_enable_pin,
  input  wire logic        retime_skip_select,
  input  wire logic        control_in_first,
  input  wire logic        control_in_second,
  // Gate drives
  output logic             gate_drive_a,
  output logic             gate_drive_b,
  output logic             gate_drive_c,
  output logic             gate_drive_d,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic        en_meta;
    logic        en_sync;
    logic        bp_meta;
    logic        bp_sync;
    logic        en_prev;
    logic [1:0]  retime;
    logic [6:0]  on_cnt;
    logic        ready;
    logic        sw_en;
    logic        sw_bp;
    logic [3:0]  drive;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rtz_state_type;

  localparam rtz_state_type STATE_RESET = '{
    retime: RETIME_RESET, sw_en: CTRL_RESET[CTRL_EN_BIT], sw_bp: CTRL_RESET[CTRL_BP_BIT],
    drive: DRIVE_DEFAULT, default: '0};

  rtz_state_type state_ff;
  rtz_state_type nxt_state;
  rtz_decode_if  dif ();
  logic          en_eff;
  logic          bp_eff;
  logic          access;
  logic [1:0]    live_code;

  rtz_decoder u_decoder (.dif(dif.dec));

  ////////////////////////////////////////////////////////////////////////////////
  // Effective enable and bypass, pin AND/OR software control
  assign en_eff    = state_ff.en_sync & state_ff.sw_en;
  assign bp_eff    = state_ff.bp_sync | state_ff.sw_bp;
  assign live_code = {control_in_first, control_in_second};
  assign access    = psel & penable & ~state_ff.pready;
  assign dif.code  = bp_eff ? live_code : state_ff.retime;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state          = state_ff;
    // Pin synchronisers
    nxt_state.en_meta  = pulser_enable_pin;
    nxt_state.en_sync  = state_ff.en_meta;
    nxt_state.bp_meta  = retime_skip_select;
    nxt_state.bp_sync  = state_ff.bp_meta;
    nxt_state.en_prev  = en_eff;
    // Retiming flops: reset on enable edge or while disabled, hold in bypass, capture otherwise
    if (!en_eff || (en_eff != state_ff.en_prev)) begin
      nxt_state.retime = RETIME_RESET;
    end else if (!bp_eff) begin
      nxt_state.retime = live_code;
    end
    // Power-up timer
    if (!en_eff) begin
      nxt_state.on_cnt = '0;
    end else if (state_ff.on_cnt != ON_COUNT) begin
      nxt_state.on_cnt = state_ff.on_cnt + 7'h01;
    end
    nxt_state.ready    = en_eff && (nxt_state.on_cnt == ON_COUNT);
    // Output drive pattern
    if (en_eff && state_ff.ready) begin
      nxt_state.drive  = dif.drive;
    end else begin
      nxt_state.drive  = DRIVE_DEFAULT;
    end
    // APB access phase, one wait state
    nxt_state.pready   = access;
    nxt_state.pslverr  = 1'b0;
    if (access) begin
      unique case (paddr)
        ADDR_CTRL: begin
          if (pwrite) begin
            nxt_state.sw_en = pwdata[CTRL_EN_BIT];
            nxt_state.sw_bp = pwdata[CTRL_BP_BIT];
          end
          nxt_state.prdata = {30'h0, state_ff.sw_bp, state_ff.sw_en};
        end
        ADDR_STATUS: begin
          nxt_state.prdata = '0;
          nxt_state.prdata[STAT_EN_BIT] = en_eff;
          nxt_state.prdata[STAT_RDY_BIT] = state_ff.ready;
          nxt_state.prdata[STAT_BP_BIT] = bp_eff;
          nxt_state.prdata[STAT_CODE_LSB +: 2] = state_ff.retime;
          nxt_state.prdata[STAT_DRV_LSB +: 4] = state_ff.drive;
        end
        default: begin
          nxt_state.prdata  = '0;
          nxt_state.pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= STATE_RESET;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flops
  assign gate_drive_a = state_ff.drive[3];
  assign gate_drive_b = state_ff.drive[2];
  assign gate_drive_c = state_ff.drive[1];
  assign gate_drive_d = state_ff.drive[0];
  assign prdata       = state_ff.prdata;
  assign pready       = state_ff.pready;
  assign pslverr      = state_ff.pslverr;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Retiming flops and decode
  retime_capture_a: assert property (ce && en_eff && state_ff.en_prev && !bp_eff
    |=> state_ff.retime == $past(live_code))
    else $error("retiming flops missed the control inputs");

  bypass_decode_a: assert property (ce && en_eff && state_ff.ready && bp_eff && live_code == 2'h1
    |=> state_ff.drive == DRIVE_CODE01)
    else $error("bypass decode of code 01 wrong");

  bypass_hold_a: assert property (ce && en_eff && state_ff.en_prev && bp_eff
    |=> $stable(state_ff.retime))
    else $error("retiming flops moved in bypass");

  path_switch_a: assert property (ce && en_eff && state_ff.ready && $changed(bp_eff) && !bp_eff
    |=> state_ff.drive == $past(dif.drive))
    else $error("outputs did not follow path change");

  idle_code_a: assert property (dif.code == 2'h3
    |-> dif.drive[3] && !dif.drive[2] && dif.drive[1] && !dif.drive[0])
    else $error("all-ones code turns a switch on");

  edge_reset_a: assert property (ce && (en_eff != state_ff.en_prev)
    |=> state_ff.retime == RETIME_RESET)
    else $error("enable edge did not reset retiming flops");

  // Output pattern while disabled
  idle_drive_a: assert property (ce && !en_eff |=> state_ff.drive == DRIVE_DEFAULT)
    else $error("outputs not idle while disabled");

  drive_gate_a: assert property (state_ff.drive != DRIVE_DEFAULT |-> $past(en_eff) && $past(state_ff.ready))
    else $error("outputs active without enable");

  // Power-up and power-down timing
  ready_time_a: assert property ($rose(state_ff.ready)
    |-> $past(en_eff, ON_COUNT) && !$past(en_eff, ON_COUNT + 7'h01))
    else $error("ready raised at wrong time after enable");

  off_time_a: assert property (ce && !pulser_enable_pin ##1 ce ##1 ce ##1 ce
    |-> state_ff.drive == DRIVE_DEFAULT)
    else $error("idle state not reached after enable fell");

  // Register bus
  apb_answer_a: assert property (ce && psel && penable && !pready |=> pready)
    else $error("apb access not answered");

  apb_refuse_a: assert property (ce && psel && penable && !pready && paddr != ADDR_CTRL && paddr != ADDR_STATUS
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped apb address not refused");

  // Scenario covers
  clocked_pulse_c: cover property (en_eff && state_ff.ready && !bp_eff ##1 state_ff.drive == DRIVE_CODE01);
  bypass_pulse_c:  cover property (en_eff && state_ff.ready && bp_eff ##1 state_ff.drive == DRIVE_CODE00);
  ready_rise_c:    cover property ($rose(state_ff.ready));
  apb_error_c:     cover property (pready && pslverr);
  ce_freeze_c:     cover property (!ce ##1 ce);

endmodule : rtz_pulser_retime

// ### rtz_beamformer_model.sv
// Beamformer side model: drives the pulser pins from requests of the bench
// Assumes one clock shared with the pulser logic; pins change after rising edges
`timescale 1ns/1ps
module rtz_beamformer_model (
  // Clock and requests from the bench
  input  wire logic       clk,
  input  wire logic       en_req,
  input  wire logic       bp_req,
  input  wire logic [1:0] code_req,
  // Pins toward the pulser
  output logic            pulser_enable_pin,
  output logic            retime_skip_select,
  output logic            control_in_first,
  output logic            control_in_second
);
  ////////////////////////////////////////////////////////////////////////////////
  // Launch pins just after each rising edge of the shared 25 MHz clock; settled long before reset ends
  always @(posedge clk) begin
    pulser_enable_pin  <= en_req;
    retime_skip_select <= bp_req;
    control_in_first   <= code_req[1];
    control_in_second  <= code_req[0];
  end
endmodule : rtz_beamformer_model

// ### rtz_pulser_retime_test.sv
// Self-checking bench for the pulser control logic
// Assumes 25 MHz clk, synchronous reset and the beamformer model on the pins
`timescale 1ns/1ps
module rtz_pulser_retime_test;
  import rtz_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce_in = 1'b1;
  logic        en_req = 1'b0;
  logic        bp_req = 1'b0;
  logic [1:0]  code_req = 2'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        en_pin, bp_pin, in_first, in_second;
  logic        drv_a, drv_b, drv_c, drv_d;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          num_checks = 0;
  logic [3:0]  dec_tab [4] = '{4'h9, 4'hE, 4'h2, 4'hA};
  wire  [3:0]  drv = {drv_a, drv_b, drv_c, drv_d};

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial begin
    forever #20 clk = ~clk;
  end
  rtz_beamformer_model u_rtz_beamformer_model (.clk(clk), .en_req(en_req), .bp_req(bp_req),
    .code_req(code_req), .pulser_enable_pin(en_pin), .retime_skip_select(bp_pin),
    .control_in_first(in_first), .control_in_second(in_second));
  rtz_pulser_retime u_rtz_pulser_retime (.clk(clk), .reset(reset), .ce(ce_in), .pulser_enable_pin(en_pin),
    .retime_skip_select(bp_pin), .control_in_first(in_first), .control_in_second(in_second),
    .gate_drive_a(drv_a), .gate_drive_b(drv_b), .gate_drive_c(drv_c), .gate_drive_d(drv_d),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Let some edges pass, then look at settled outputs
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : edges

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset_regs();
    check(drv, 4'hA);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check({err, rd[1:0]}, 3'h1);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
  endtask : test_reset_regs

  task automatic test_power_up();
    en_req <= 1'b1;
    edges(60);
    check(drv, 4'hA);
    edges(70);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], 2'h3);
    check(drv, dec_tab[0]);
  endtask : test_power_up

  // Each code shows only one edge after its capture edge
  task automatic test_clocked();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      code_req <= 2'((k + 1) % 4);
      edges(1);
      check(drv, dec_tab[k]);
      edges(2);
      check(drv, dec_tab[(k + 1) % 4]);
    end
  endtask : test_clocked

  // Clock enable low freezes capture and outputs
  task automatic test_freeze();
    @(posedge clk);
    ce_in <= 1'b0;
    code_req <= 2'h2;
    edges(6);
    check(drv, dec_tab[0]);
    @(posedge clk);
    ce_in <= 1'b1;
    edges(6);
    check(drv, dec_tab[2]);
    code_req <= 2'h0;
    edges(4);
    check(drv, dec_tab[0]);
  endtask : test_freeze

  task automatic test_bypass();
    bp_req <= 1'b1;
    edges(6);
    check(drv, dec_tab[0]);
    for (int k = 3; k >= 0; k--) begin
      code_req <= 2'(k);
      edges(4);
      check(drv, dec_tab[k]);
    end
    bp_req <= 1'b0;
    code_req <= 2'h1;
    edges(6);
    check(drv, dec_tab[1]);
  endtask : test_bypass

  task automatic test_ctrl_write();
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd[1:0], 2'h0);
    edges(4);
    check(drv, 4'hA);
    apb(1'b1, ADDR_CTRL, 32'h1);
    edges(130);
    check(drv, dec_tab[1]);
  endtask : test_ctrl_write

  task automatic test_disable();
    en_req <= 1'b0;
    edges(5);
    check(drv, 4'hA);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[5:4], 2'h3);
    check(rd[11:8], 4'hA);
    bp_req <= 1'b1;
    code_req <= 2'h0;
    edges(6);
    check(drv, 4'hA);
  endtask : test_disable

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    edges(1);
    test_reset_regs();
    test_power_up();
    test_clocked();
    test_freeze();
    test_bypass();
    test_ctrl_write();
    test_disable();
    final_report();
  end
endmodule : rtz_pulser_retime_test
